/* File: design/comparator_control_params.svh */
`ifndef COMPARATOR_CONTROL_PARAMS_SVH
`define COMPARATOR_CONTROL_PARAMS_SVH

// register byte offsets
`define CMP_CTRL_OFFSET 8'h00
`define CMP_IRQ_STATUS_OFFSET 8'h04
`define CMP_IRQ_MASK_OFFSET 8'h08

// control register field positions
`define CMP_ENABLE_BIT 15
`define CMP_OUT_PIN_DRIVE_BIT 14
`define CMP_RESULT_INVERT_BIT 13
`define CMP_RESULT_VIEW_BIT 8
`define CMP_EDGE_SEL_HI 7
`define CMP_EDGE_SEL_LO 6
`define CMP_POS_SEL_BIT 4
`define CMP_NEG_SEL_HI 1
`define CMP_NEG_SEL_LO 0

// writable bits: 15,14,13,7,6,4,1,0
`define CMP_CTRL_WMASK 32'h0000e0d3
// reset value of the control register
`define CMP_CTRL_RESET 32'h000000c3

// event codes of the edge select field
`define CMP_EDGE_OFF 2'h0
`define CMP_EDGE_RISE 2'h1
`define CMP_EDGE_FALL 2'h2
`define CMP_EDGE_BOTH 2'h3

// negative input routing codes
`define CMP_NEG_EXT_B 2'h0
`define CMP_NEG_EXT_C 2'h1
`define CMP_NEG_EXT_D 2'h2
`define CMP_NEG_BANDGAP 2'h3

// irq status and mask: bit 0 is the comparator event
`define CMP_IRQ_EVENT_BIT 0

// ahb htrans code for a nonsequential transfer
`define AHB_HTRANS_NONSEQ 2'h2

`endif

/* File: design/comparator_control_pkg.sv */
package comparator_control_pkg;

   typedef enum logic [1:0] {
      edge_off_t_val = 2'h0,
      edge_rise_t_val = 2'h1,
      edge_fall_t_val = 2'h2,
      edge_both_t_val = 2'h3
   } edge_select_t;

   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_write = 3'b010,
      st_read = 3'b100
   } bus_state_t;

endpackage : comparator_control_pkg

/* File: design/sync_edge_detect.sv */
`timescale 1ns/100ps
// two-flop synchroniser followed by an edge detector on the second stage
module sync_edge_detect
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // asynchronous level in
   input wire logic async_in,
   // synchronised level and edges
   output logic sync_out,
   output logic rise_pulse,
   output logic fall_pulse
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign sync_out = sync_reg;
   assign rise_pulse = sync_reg & ~prev_reg;
   assign fall_pulse = ~sync_reg & prev_reg;

endmodule : sync_edge_detect

/* File: design/comparator_control.sv */
// Contract
// - Setting the enable bit turns the comparator on and changes no other field.
// - Clearing the enable bit turns the comparator off, other fields keep their value.
// - With output drive set the result goes to the result pin, otherwise it does not.
// - With result invert set the comparator result is inverted before use.
// - Bit 8 is a read-only view of the comparator result, unaffected by writes.
// - The edge select field picks no event, rising, falling, or both edges.
// - The inversion also applies ahead of the event edge detector.
// - Positive select picks the internal reference when one, input a when zero.
// - Negative select routes input b, c, d or the band-gap reference.
// - Unimplemented control bits read as zero and ignore writes.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "comparator_control_params.svh"
module comparator_control
   import comparator_control_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // analog core controls and raw result
   output logic comp_enable,
   output logic pos_input_select,
   output logic [1:0] neg_input_select,
   input wire logic comp_raw_out,
   // result pin, output only
   output logic result_pin,
   output logic result_pin_oe,
   // event and interrupt
   output logic event_pulse,
   output logic irq
);

   bus_state_t state_reg;
   bus_state_t state_next;
   logic [7:0] addr_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic irq_status_reg;
   logic irq_status_next;
   logic irq_mask_reg;
   logic irq_mask_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // analog result synchronised before any use
   logic sync_level;
   logic sync_rise;
   logic sync_fall;

   sync_edge_detect u_sync
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(comp_raw_out),
      .sync_out(sync_level),
      .rise_pulse(sync_rise),
      .fall_pulse(sync_fall)
   );

   // field views
   wire enable_bit = ctrl_reg[`CMP_ENABLE_BIT];
   wire drive_bit = ctrl_reg[`CMP_OUT_PIN_DRIVE_BIT];
   wire invert_bit = ctrl_reg[`CMP_RESULT_INVERT_BIT];
   wire [1:0] irq_edge_select =
      ctrl_reg[`CMP_EDGE_SEL_HI:`CMP_EDGE_SEL_LO];

   // a disabled core gives a low result
   wire result_view = enable_bit & (sync_level ^ invert_bit);
   // inverting swaps which raw edge counts as rising
   wire pol_rise = invert_bit ? sync_fall : sync_rise;
   wire pol_fall = invert_bit ? sync_rise : sync_fall;

   wire rise_hit = irq_edge_select[0] & pol_rise;
   wire fall_hit = irq_edge_select[1] & pol_fall;
   // edges seen while disabled are dropped; an edge reaching the detector after re-enabling still raises an event
   wire edge_hit = enable_bit & (rise_hit | fall_hit);

   assign event_pulse = edge_hit;
   assign comp_enable = enable_bit;
   assign pos_input_select = ctrl_reg[`CMP_POS_SEL_BIT];
   assign neg_input_select =
      ctrl_reg[`CMP_NEG_SEL_HI:`CMP_NEG_SEL_LO];
   assign result_pin = drive_bit & result_view;
   assign result_pin_oe = drive_bit & enable_bit;
   assign irq = irq_status_reg & irq_mask_reg;

   // bus decode
   wire take = hsel & hready & (htrans == `AHB_HTRANS_NONSEQ);
   wire take_wr = take & hwrite;
   wire take_rd = take & ~hwrite;
   wire hit_ctrl = (addr_reg == `CMP_CTRL_OFFSET);
   wire hit_stat = (addr_reg == `CMP_IRQ_STATUS_OFFSET);
   wire hit_mask = (addr_reg == `CMP_IRQ_MASK_OFFSET);
   wire wr_phase = (state_reg == st_write);
   wire rd_phase = (state_reg == st_read);

   // live read value; the result bit is not a stored field
   wire [31:0] ctrl_view = (ctrl_reg & `CMP_CTRL_WMASK) |
      ({31'h0, result_view} << `CMP_RESULT_VIEW_BIT);
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_view :
      hit_stat ? {31'h0, irq_status_reg} :
      hit_mask ? {31'h0, irq_mask_reg} :
      32'h0;
   // read data is sampled at the address phase so it stands in the data phase
   wire [7:0] rd_addr = haddr;
   wire [31:0] rd_now =
      (rd_addr == `CMP_CTRL_OFFSET) ? ctrl_view :
      (rd_addr == `CMP_IRQ_STATUS_OFFSET) ? {31'h0, irq_status_reg} :
      (rd_addr == `CMP_IRQ_MASK_OFFSET) ? {31'h0, irq_mask_reg} :
      32'h0;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         st_idle,
         st_write,
         st_read:
         begin
            if (take_wr)
               state_next = st_write;
            else if (take_rd)
               state_next = st_read;
            else
               state_next = st_idle;
         end
         default:
            state_next = st_idle;
      endcase
   end

   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (wr_phase && hit_ctrl)
         // only implemented bits take the write
         ctrl_next = hwdata & `CMP_CTRL_WMASK;
   end

   always_comb
   begin
      irq_status_next = irq_status_reg;
      if (wr_phase && hit_stat && hwdata[`CMP_IRQ_EVENT_BIT])
         irq_status_next = 1'b0;
      // a new event wins over a clear in the same cycle
      if (edge_hit)
         irq_status_next = 1'b1;
   end

   always_comb
   begin
      irq_mask_next = irq_mask_reg;
      if (wr_phase && hit_mask)
         irq_mask_next = hwdata[`CMP_IRQ_EVENT_BIT];
   end

   always_comb
   begin
      rdata_next = rdata_reg;
      if (take_rd)
         rdata_next = rd_now;
      else if (rd_phase)
         rdata_next = rd_mux;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= st_idle;
         addr_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (take)
            addr_reg <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= `CMP_CTRL_RESET;
         irq_status_reg <= 1'b0;
         irq_mask_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg <= rdata_next;
      end
   end

   // zero wait states; the slave never stalls
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

endmodule : comparator_control

/* File: dv/comparator_control_sva.sv */
`timescale 1ns/100ps
module cmp_ctrl_sva
(
   // clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // block outputs and the raw comparator result
   input wire logic comp_enable,
   input wire logic [1:0] neg_input_select,
   input wire logic comp_raw_out,
   input wire logic result_pin,
   input wire logic result_pin_oe,
   input wire logic event_pulse,
   input wire logic irq
);
   logic wr_reg;
   logic rd_reg;
   wire logic take = hsel && hready && htrans == 2'h2;
   wire logic rd0 = take && !hwrite && haddr == 8'h00;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {wr_reg, rd_reg} <= 2'b00;
      else
         {wr_reg, rd_reg} <= {take && hwrite, rd0};
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   en_cause_a: assert property
      ($changed(comp_enable) |-> $past(wr_reg)) else $error("stray enable");
   neg_cause_a: assert property
      ($changed(neg_input_select) |-> $past(wr_reg)) else $error("stray mux");
   pin_idle_a: assert property
      (!result_pin_oe |-> !result_pin) else $error("pin driven while off");
   oe_off_a: assert property
      (!comp_enable |-> !result_pin_oe) else $error("pin on while disabled");
   pulse_one_a: assert property
      (event_pulse |=> !event_pulse) else $error("long event pulse");
   // four quiet samples outlast the synchroniser and the edge detector
   quiet_in_a: assert property
      ($stable({comp_raw_out, comp_enable})[*4] |-> !event_pulse)
      else $error("event without edge");
   irq_cause_a: assert property
      ($rose(irq) |-> $past(event_pulse) || $past(wr_reg))
      else $error("irq without event");
   rsvd_zero_a: assert property
      (rd_reg |-> (hrdata & 32'hffff1e2c) == 32'h0) else $error("reserved set");
endmodule : cmp_ctrl_sva

/* File: dv/cmp_core_model.sv */
`timescale 1ns/100ps
module cmp_core_model
(
   // settings from the block
   input wire logic comp_enable,
   input wire logic pos_input_select,
   input wire logic [1:0] neg_input_select,
   // levels: reference over input a; bandgap, d, c, b
   input wire logic [15:0] pos_lv,
   input wire logic [31:0] neg_lv,
   // comparison result
   output logic comp_raw_out
);
   wire logic [7:0] vp = pos_lv[8 * pos_input_select +: 8];
   wire logic [7:0] vn = neg_lv[8 * neg_input_select +: 8];
   // a powered-down core holds its output low instead of floating
   assign comp_raw_out = comp_enable && vp > vn;
endmodule : cmp_core_model

/* File: dv/comparator_control_tb_top.sv */
`timescale 1ns/100ps
module comparator_control_tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] lvl_b = 8'h28;
   logic [31:0] hrdata, rd;
   logic hready, hresp, comp_enable, pos_input_select, comp_raw_out;
   logic result_pin, result_pin_oe, event_pulse, irq;
   logic [1:0] neg_input_select;
   int fails = 0;
   int checks = 0;
   always #10 hclk = ~hclk;
   comparator_control comparator_control_i (.hclk, .hresetn, .hsel(1'b1),
      .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata,
      .hreadyout(hready), .hresp, .comp_enable, .pos_input_select,
      .neg_input_select, .comp_raw_out, .result_pin, .result_pin_oe,
      .event_pulse, .irq);
   cmp_core_model cmp_core_model_i (.comp_enable, .pos_input_select,
      .neg_input_select, .pos_lv(16'h6432), .neg_lv({24'h78503c, lvl_b}),
      .comp_raw_out);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial
   begin
      #400000;
      fails++;
      test_done();
   end
   initial
   begin
      logic e;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h000000c3);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      // every input route, with ones thrown at the reserved bits
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, 8'h00, 32'hffffdf20 | {i[2], 2'b11, i[1:0]});
         e = i[2] ? i[1:0] != 2'h3 : i[1:0] == 2'h0;
         repeat (4) @(posedge hclk);
         bus(1'b0, 8'h00, 32'h0);
         chk(rd, {16'h0, 7'h60, e, 3'h0, i[2], 2'h0, i[1:0]});
         chk({comp_enable, pos_input_select, neg_input_select}, {1'b1, i[2:0]});
         chk(result_pin, e);
      end
      bus(1'b1, 8'h00, 32'h0000e000);
      // the new route settles through the synchroniser before the read
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000e000);
      chk(result_pin, 1'b0);
      bus(1'b1, 8'h00, 32'h00006000);
      @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h00006000);
      chk({comp_enable, result_pin_oe}, 2'b00);
      // invert changes only with events off, so it cannot fake an edge
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, 8'h00, 32'h8000 | i[2] << 13);
         bus(1'b1, 8'h08, {31'h0, i[1:0] != 2'h3});
         bus(1'b1, 8'h00, 32'h8000 | i[2] << 13 | i[1:0] << 6);
         for (int k = 0; k < 2; k++)
         begin
            lvl_b <= k ? 8'h28 : 8'h46;
            e = (k ^ i[2]) ? i[0] : i[1];
            repeat (6) @(posedge hclk);
            chk(irq, e & (i[1:0] != 2'h3));
            bus(1'b0, 8'h04, 32'h0);
            chk(rd, e);
            bus(1'b1, 8'h04, 32'h1);
         end
         bus(1'b1, 8'h00, 32'h8000 | i[2] << 13);
      end
      bus(1'b0, 8'h04, 32'h0);
      chk({rd[0], irq, hresp}, 3'b000);
      test_done();
   end
endmodule : comparator_control_tb_top
bind comparator_control cmp_ctrl_sva cmp_ctrl_sva_i (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .comp_enable, .neg_input_select,
   .comp_raw_out, .result_pin, .result_pin_oe, .event_pulse, .irq);
